// ===== hdl/regulator_irq.v
// Interrupt mask, sense and identification registers of a buck converter.
// Assumes a register port already decoded from the serial control bus,
// on i_clock; fault inputs are raw pins from the analog side.
// Sense images are live; a sense read clears that group's latches.
//
// Functional notes
// - Mask bit 0 passes, 1 blocks
// - Mask A at 04h, D7 D3 read 1
// - Mask B at 05h, D7 D3 read 1
// - Mask A D0 gates low-side overcurrent
// - Mask A D1 overcurrent, D2 short circuit
// - Mask A D4 OV, D5 UV, D6 lockout
// - Mask B D0 gates power good
// - Mask B D1 clock, D2 double write
// - Mask B D4-D6 thermal levels
// - Product ID at 06h, fixed, read-only
// - Revision ID at 07h, read-only
// - Live sense bits readable per source
`timescale 1ns/1ns
`include "regulator_irq_consts.vh"
module regulator_irq (
    input  wire       i_clock,
    input  wire       i_rst_n,
    input  wire       i_reg_wr,
    input  wire       i_reg_rd,
    input  wire [7:0] i_reg_addr,
    input  wire [7:0] i_reg_wdata,
    input  wire       i_low_side_oc,
    input  wire       i_output_oc,
    input  wire       i_short_circuit,
    input  wire       i_overvoltage,
    input  wire       i_undervoltage,
    input  wire       i_input_lockout,
    input  wire       i_power_good,
    input  wire       i_clock_indicator,
    input  wire       i_double_write_err,
    input  wire       i_thermal_prewarn,
    input  wire       i_thermal_warning,
    input  wire       i_thermal_shutdown,
    output reg  [7:0] o_reg_rdata,
    output reg        o_reg_rvalid,
    output reg        o_irq_n
);

    // ************************************************************
    // Input synchronisers
    // ************************************************************
    wire [11:0] raw;
    reg  [11:0] sync1_r;
    reg  [11:0] sync2_r;
    reg  [11:0] sync3_r;
    reg  [11:0] stable_r;
    wire [11:0] stable_nxt;

    assign raw = {i_thermal_shutdown, i_thermal_warning, i_thermal_prewarn,
                  i_double_write_err, i_clock_indicator, i_power_good,
                  i_input_lockout, i_undervoltage, i_overvoltage,
                  i_short_circuit, i_output_oc, i_low_side_oc};

    // A bit changes only when stages two and three agree, so a pin
    // level must be seen on two edges in a row before it counts
    genvar s;
    generate
        for (s = 0; s < 12; s = s + 1) begin : g_filter
            assign stable_nxt[s] = (sync2_r[s] & sync3_r[s]) |
                                   (stable_r[s] & (sync2_r[s] | sync3_r[s]));
        end
    endgenerate

    always @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sync1_r  <= 12'h000;
            sync2_r  <= 12'h000;
            sync3_r  <= 12'h000;
            stable_r <= 12'h000;
        end else begin
            sync1_r  <= raw;
            sync2_r  <= sync1_r;
            sync3_r  <= sync2_r;
            stable_r <= stable_nxt;
        end
    end

    // ************************************************************
    // Sense register images
    // ************************************************************
    wire [7:0] sense_a;
    wire [7:0] sense_b;

    // Spare positions D7 and D3 of both images read 0
    assign sense_a[7]                  = 1'b0;
    assign sense_a[3]                  = 1'b0;
    assign sense_a[`BIT_A_LOW_SIDE_OC] = stable_r[0];
    assign sense_a[`BIT_A_OUTPUT_OC]   = stable_r[1];
    assign sense_a[`BIT_A_SHORT]       = stable_r[2];
    assign sense_a[`BIT_A_OVERVOLT]    = stable_r[3];
    assign sense_a[`BIT_A_UNDERVOLT]   = stable_r[4];
    assign sense_a[`BIT_A_LOCKOUT]     = stable_r[5];

    assign sense_b[7]                  = 1'b0;
    assign sense_b[3]                  = 1'b0;
    assign sense_b[`BIT_B_POWER_GOOD]  = stable_r[6];
    assign sense_b[`BIT_B_CLOCK_IND]   = stable_r[7];
    assign sense_b[`BIT_B_DOUBLE_WR]   = stable_r[8];
    assign sense_b[`BIT_B_PREWARN]     = stable_r[9];
    assign sense_b[`BIT_B_WARNING]     = stable_r[10];
    assign sense_b[`BIT_B_SHUTDOWN]    = stable_r[11];

    // ************************************************************
    // Register decode
    // ************************************************************
    // A read and a write in one cycle both act; the read sees old data
    wire       wr_mask_a;
    wire       wr_mask_b;
    wire       rd_sense_a;
    wire       rd_sense_b;

    assign wr_mask_a  = i_reg_wr && (i_reg_addr == `ADDR_MASK_A);
    assign wr_mask_b  = i_reg_wr && (i_reg_addr == `ADDR_MASK_B);
    assign rd_sense_a = i_reg_rd && (i_reg_addr == `ADDR_SENSE_A);
    assign rd_sense_b = i_reg_rd && (i_reg_addr == `ADDR_SENSE_B);

    // ************************************************************
    // Mask registers
    // ************************************************************
    reg  [7:0] fault_interrupt_mask_a_r;
    reg  [7:0] fault_interrupt_mask_b_r;

    always @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            fault_interrupt_mask_a_r <= `MASK_A_RESET;
            fault_interrupt_mask_b_r <= `MASK_B_RESET;
        end else begin
            // Spares forced to 1 so they never gate anything
            if (wr_mask_a) begin
                fault_interrupt_mask_a_r <= i_reg_wdata | `MASK_SPARE_BITS;
            end
            if (wr_mask_b) begin
                fault_interrupt_mask_b_r <= i_reg_wdata | `MASK_SPARE_BITS;
            end
        end
    end

    // ************************************************************
    // Latched sources: reading a sense register clears its latches
    // ************************************************************
    wire [7:0] clear_a;
    wire [7:0] clear_b;
    wire       any_a;
    wire       any_b;

    // A source still live at the read keeps its latch set
    assign clear_a = rd_sense_a ? 8'hFF : 8'h00;
    assign clear_b = rd_sense_b ? 8'hFF : 8'h00;

    source_latch u_latch_a (
        .i_clock   (i_clock),
        .i_rst_n   (i_rst_n),
        .i_live    (sense_a),
        .i_clear   (clear_a),
        .i_mask    (fault_interrupt_mask_a_r),
        .o_latched (),
        .o_any     (any_a)
    );

    source_latch u_latch_b (
        .i_clock   (i_clock),
        .i_rst_n   (i_rst_n),
        .i_live    (sense_b),
        .i_clear   (clear_b),
        .i_mask    (fault_interrupt_mask_b_r),
        .o_latched (),
        .o_any     (any_b)
    );

    // ************************************************************
    // Interrupt output
    // ************************************************************
    wire       irq_n_nxt;

    // Registered so the pin cannot glitch while masks or latches change
    assign irq_n_nxt = ~(any_a | any_b);

    always @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_irq_n <= 1'b1;
        end else begin
            o_irq_n <= irq_n_nxt;
        end
    end

    // ************************************************************
    // Read path
    // ************************************************************
    reg [7:0] rdata_nxt;

    always @* begin
        case (i_reg_addr)
            `ADDR_SENSE_A:     rdata_nxt = sense_a;
            `ADDR_SENSE_B:     rdata_nxt = sense_b;
            `ADDR_MASK_A:      rdata_nxt = fault_interrupt_mask_a_r;
            `ADDR_MASK_B:      rdata_nxt = fault_interrupt_mask_b_r;
            `ADDR_PRODUCT_ID:  rdata_nxt = `PRODUCT_ID_VALUE;
            `ADDR_REVISION_ID: rdata_nxt = `REVISION_ID_VALUE;
            default:           rdata_nxt = 8'h00;
        endcase
    end

    // Data holds between reads so a slow host may pick it up late
    always @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_reg_rdata <= 8'h00;
        end else if (i_reg_rd) begin
            o_reg_rdata <= rdata_nxt;
        end
    end

    always @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_reg_rvalid <= 1'b0;
        end else begin
            o_reg_rvalid <= i_reg_rd;
        end
    end

endmodule // regulator_irq

// ===== hdl/regulator_irq_consts.vh
// Constants for the regulator interrupt mask and identification block.
// Assumes inclusion by bare name from the design files under hdl/.
`ifndef REGULATOR_IRQ_CONSTS_VH
`define REGULATOR_IRQ_CONSTS_VH

// ************************************************************
// Register addresses
// ************************************************************
`define ADDR_SENSE_A      8'h02
`define ADDR_SENSE_B      8'h03
`define ADDR_MASK_A       8'h04
`define ADDR_MASK_B       8'h05
`define ADDR_PRODUCT_ID   8'h06
`define ADDR_REVISION_ID  8'h07

// ************************************************************
// Field positions, shared by sense and mask registers
// ************************************************************
`define BIT_A_LOW_SIDE_OC 0
`define BIT_A_OUTPUT_OC   1
`define BIT_A_SHORT       2
`define BIT_A_OVERVOLT    4
`define BIT_A_UNDERVOLT   5
`define BIT_A_LOCKOUT     6
`define BIT_B_POWER_GOOD  0
`define BIT_B_CLOCK_IND   1
`define BIT_B_DOUBLE_WR   2
`define BIT_B_PREWARN     4
`define BIT_B_WARNING     5
`define BIT_B_SHUTDOWN    6

// ************************************************************
// Spare positions D7 and D3
// ************************************************************
`define MASK_SPARE_BITS   8'h88
`define SENSE_USED_A      8'h77
`define SENSE_USED_B      8'h77

// ************************************************************
// Reset values: all sources masked
// ************************************************************
`define MASK_A_RESET      8'hFF
`define MASK_B_RESET      8'hFF

// ************************************************************
// Identification codes, values arbitrary
// ************************************************************
`define PRODUCT_ID_VALUE  8'h5A
`define REVISION_ID_VALUE 8'h01

`endif

// ===== hdl/source_latch.v
// Sticky latch per source with mask gating.
// Assumes sources already synchronised to i_clock.
`timescale 1ns/1ns
module source_latch (
    input  wire       i_clock,
    input  wire       i_rst_n,
    input  wire [7:0] i_live,
    input  wire [7:0] i_clear,
    input  wire [7:0] i_mask,
    output wire [7:0] o_latched,
    output wire       o_any
);
    reg  [7:0] latch_r;
    wire [7:0] latch_nxt;
    genvar g;
    generate
        for (g = 0; g < 8; g = g + 1) begin : g_bit
            // Set wins over a clear in the same cycle
            assign latch_nxt[g] = i_live[g] | (latch_r[g] & ~i_clear[g]);
        end
    endgenerate
    always @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            latch_r <= 8'h00;
        end else begin
            latch_r <= latch_nxt;
        end
    end
    assign o_latched = latch_r;
    assign o_any     = |(latch_r & ~i_mask);
endmodule // source_latch

// ===== test/regulator_irq_monitor.sv
// Assertions on the register port and interrupt pin of regulator_irq.
// Assumes it is bound onto regulator_irq.
`timescale 1ns/1ns
`include "regulator_irq_consts.vh"
module irq_monitor (
    input wire       i_clock,
    input wire       i_rst_n,
    input wire       i_reg_wr,
    input wire       i_reg_rd,
    input wire [7:0] i_reg_addr,
    input wire [7:0] i_reg_wdata,
    input wire [7:0] o_reg_rdata,
    input wire       o_reg_rvalid,
    input wire       o_irq_n
);
    reg  [7:0] ma_r;
    reg  [7:0] mb_r;
    wire       rdo = i_reg_rd && !i_reg_wr;
    wire [7:0] a   = i_reg_addr;
    // Shadow masks, spares forced high
    always @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ma_r <= `MASK_A_RESET;
            mb_r <= `MASK_B_RESET;
        end else if (i_reg_wr && a == `ADDR_MASK_A) begin
            ma_r <= i_reg_wdata | `MASK_SPARE_BITS;
        end else if (i_reg_wr && a == `ADDR_MASK_B) begin
            mb_r <= i_reg_wdata | `MASK_SPARE_BITS;
        end
    end
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);
    rvalid_after_rd_a: assert property (i_reg_rd |=> o_reg_rvalid) else $error("rvalid late");
    rvalid_cause_a: assert property (o_reg_rvalid |-> $past(i_reg_rd)) else $error("stray rvalid");
    rdata_hold_a: assert property (!i_reg_rd |=> $stable(o_reg_rdata)) else $error("rdata moved");
    mask_a_read_a: assert property (rdo && a == `ADDR_MASK_A |=>
        o_reg_rdata == $past(ma_r)) else $error("mask a readback");
    mask_b_read_a: assert property (rdo && a == `ADDR_MASK_B |=>
        o_reg_rdata == $past(mb_r)) else $error("mask b readback");
    product_id_a: assert property (i_reg_rd && a == `ADDR_PRODUCT_ID |=>
        o_reg_rdata == `PRODUCT_ID_VALUE) else $error("product id");
    revision_id_a: assert property (i_reg_rd && a == `ADDR_REVISION_ID |=>
        o_reg_rdata == `REVISION_ID_VALUE) else $error("revision id");
    unmapped_zero_a: assert property (i_reg_rd && (a < 8'h02 || a > 8'h07) |=>
        o_reg_rdata == 8'h00) else $error("unmapped read");
    masked_quiet_a: assert property ((&ma_r && &mb_r) [*3] |-> o_irq_n)
        else $error("irq while all masked");
    cover property (rdo && a == `ADDR_MASK_B);
    cover property ($fell(o_irq_n));
    cover property ($rose(o_irq_n));
endmodule // irq_monitor
bind regulator_irq irq_monitor mon (.i_clock, .i_rst_n, .i_reg_wr, .i_reg_rd, .i_reg_addr,
    .i_reg_wdata, .o_reg_rdata, .o_reg_rvalid, .o_irq_n);

// ===== test/bus_host.sv
// Register bus host model: one strobed access per call.
// Assumes the device samples on the rising edge of i_clock.
`timescale 1ns/1ns
module bus_host (
    input  wire       i_clock,
    output reg        o_wr,
    output reg        o_rd,
    output reg  [7:0] o_addr,
    output reg  [7:0] o_wdata
);
    initial {o_wr, o_rd, o_addr, o_wdata} = 18'h0FF00;
    // Released lines show the inverse so stale values never look valid
    task automatic xfer(input bit w, input [7:0] a, input [7:0] d);
        begin
            @(posedge i_clock);
            #1 {o_wr, o_rd, o_addr, o_wdata} = {w, !w, a, d};
            @(posedge i_clock);
            #1 {o_wr, o_rd, o_addr, o_wdata} = {2'b00, ~a, ~d};
        end
    endtask
endmodule // bus_host

// ===== test/testbench.sv
// Self-checking bench: ids, mask readback, per-source sense and interrupt.
// Assumes bus_host and irq_monitor are compiled alongside.
`timescale 1ns/1ns
`include "regulator_irq_consts.vh"
module testbench;
    reg         i_clock;
    reg         i_rst_n;
    reg  [11:0] f;
    wire        wr, rd, rv, irq_n;
    wire [7:0]  ad, wd, rdat;
    reg  [7:0]  exp_q[$];
    reg  [7:0]  v;
    integer     n_errors, n_checks, i, p;
    bus_host host (.i_clock(i_clock), .o_wr(wr), .o_rd(rd), .o_addr(ad), .o_wdata(wd));
    regulator_irq uut (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_reg_wr(wr), .i_reg_rd(rd),
        .i_reg_addr(ad), .i_reg_wdata(wd), .i_low_side_oc(f[0]), .i_output_oc(f[1]),
        .i_short_circuit(f[2]), .i_overvoltage(f[3]), .i_undervoltage(f[4]),
        .i_input_lockout(f[5]), .i_power_good(f[6]), .i_clock_indicator(f[7]),
        .i_double_write_err(f[8]), .i_thermal_prewarn(f[9]), .i_thermal_warning(f[10]),
        .i_thermal_shutdown(f[11]), .o_reg_rdata(rdat), .o_reg_rvalid(rv), .o_irq_n(irq_n));
    initial begin
        i_clock = 1'b0;
        forever #10 i_clock = ~i_clock;
    end
    task fail(input [7:0] x);
        begin
            n_errors = n_errors + 1;
            $display("[FAIL] %0t got %h", $time, x);
        end
    endtask
    task tally_and_finish;
        begin
            if (exp_q.size() != 0) fail(8'hEE);
            $display("checks %0d errors %0d", n_checks, n_errors);
            if (n_errors == 0 && n_checks > 0)
                $display("verification passed");
            else
                $display("verification failed");
            $finish;
        end
    endtask
    task rd_exp(input [7:0] a, input [7:0] e);
        begin
            exp_q.push_back(e);
            host.xfer(1'b0, a, 8'h00);
        end
    endtask
    task chk_irq(input e);
        begin
            #1 n_checks = n_checks + 1;
            if (irq_n !== e) fail({7'h00, irq_n});
        end
    endtask
    // Read answers matched against the oldest note
    always @(negedge i_clock) if (rv === 1'b1) begin
        n_checks = n_checks + 1;
        if (exp_q.size() == 0) fail(rdat);
        else if (rdat !== exp_q.pop_front()) fail(rdat);
    end
    initial begin
        {n_errors, n_checks, f, i_rst_n} = 0;
        v = $urandom(32'h4bd8);
        repeat (20) @(posedge i_clock);
        #1 i_rst_n = 1'b1;
        rd_exp(`ADDR_MASK_A, `MASK_A_RESET);
        rd_exp(`ADDR_MASK_B, `MASK_B_RESET);
        host.xfer(1'b1, `ADDR_PRODUCT_ID, 8'h00);
        rd_exp(`ADDR_PRODUCT_ID, `PRODUCT_ID_VALUE);
        rd_exp(`ADDR_REVISION_ID, `REVISION_ID_VALUE);
        rd_exp(8'h08 + 8'($urandom % 248), 8'h00);
        $display("test ids done");
        for (i = 0; i < 4; i++) begin
            v = $urandom;
            host.xfer(1'b1, `ADDR_MASK_A + i[0], v);
            rd_exp(`ADDR_MASK_A + i[0], v | `MASK_SPARE_BITS);
        end
        $display("test masks done");
        for (i = 0; i < 12; i++) begin
            p = (i % 6) + ((i % 6) > 2);
            host.xfer(1'b1, `ADDR_MASK_A, 8'hFF);
            host.xfer(1'b1, `ADDR_MASK_B, 8'hFF);
            f = 12'h001 << i;
            repeat (10) @(posedge i_clock);
            chk_irq(1'b1);
            host.xfer(1'b1, `ADDR_MASK_A + i / 6, ~(8'h01 << p));
            repeat (3) @(posedge i_clock);
            chk_irq(1'b0);
            rd_exp(`ADDR_SENSE_A + i / 6, 8'h01 << p);
            f = 12'h000;
            repeat (8) @(posedge i_clock);
            chk_irq(1'b0);
            rd_exp(`ADDR_SENSE_A + i / 6, 8'h00);
            repeat (3) @(posedge i_clock);
            chk_irq(1'b1);
        end
        $display("test sources done");
        tally_and_finish;
    end
    initial begin
        #400000 fail(8'hDD);
        tally_and_finish;
    end
endmodule // testbench
